// ---- hw/csq_pkg.sv ----
// Package: constants, types and script table of the CAM routine sequencer
package csq_pkg;
    // Cycle timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_SHORT_NS = 30;
    localparam int T_MED_NS = 50;
    localparam int T_LONG_NS = 70;
    localparam int SHORT_CYC =
        (T_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MED_CYC = (T_MED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LONG_CYC = (T_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // CAM command and data words
    localparam logic [15:0] CMD_SEL_BG = 16'h0619;
    localparam logic [15:0] CMD_SEL_FG = 16'h0618;
    localparam logic [15:0] CMD_TGT_ADDR = 16'h0220;
    localparam logic [15:0] CMD_TGT_DEV = 16'h0228;
    localparam logic [15:0] CMD_EMPTY_ALL = 16'h043d;
    localparam logic [15:0] CMD_EMPTY_HM = 16'h042d;
    localparam logic [15:0] CMD_NEXT_FREE = 16'h0334;
    localparam logic [15:0] DATA_ALL_ONES = 16'hffff;
    localparam logic [15:0] DATA_DONT_CARE = 16'h0000;
    // Pin levels
    localparam logic PIN_H = 1'b1;
    localparam logic PIN_L = 1'b0;
    // Step indices
    localparam logic [3:0] STEP_CMP = 4'h3;
    localparam logic [3:0] RD_FIRST_STEP = 4'h3;
    localparam logic [3:0] RD_LAST_STEP = 4'h8;
    localparam logic [3:0] RD_ALLDEV_STEP = 4'ha;

    typedef enum logic [2:0] {
        RT_DA, RT_SA, RT_PURGE, RT_ADD, RT_DEL, RT_SETADD, RT_READ
    } csq_rt_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_SETUP = 2'b01, ST_ARM = 2'b11, ST_CYC = 2'b10
    } csq_state_t;
    typedef enum logic [1:0] {LEN_S, LEN_M, LEN_L} csq_len_t;
    typedef enum logic [2:0] {
        DS_CONST, DS_A0, DS_A1, DS_A2, DS_W0, DS_TS, DS_OPU, DS_OPL
    } csq_dsel_t;
    typedef struct packed {
        logic cm_b;
        logic w_b;
        csq_len_t len;
        logic ec_b;
        csq_dsel_t dsel;
        logic [15:0] cval;
        logic last;
    } csq_line_t;

    function automatic logic [7:0] len_cycles(input csq_len_t len);
        case (len)
            LEN_S: len_cycles = 8'(SHORT_CYC);
            LEN_M: len_cycles = 8'(MED_CYC);
            default: len_cycles = 8'(LONG_CYC);
        endcase
    endfunction : len_cycles

    function automatic csq_line_t mk(input logic cm_b, input logic w_b,
            input csq_len_t len, input logic ec_b, input csq_dsel_t ds,
            input logic [15:0] cv, input logic last);
        mk = '{cm_b, w_b, len, ec_b, ds, cv, last};
    endfunction : mk

    // One line of a routine script; hit chooses the source-search branch
    function automatic csq_line_t script_line(input csq_rt_t rt,
            input logic [3:0] step, input logic hit);
        csq_line_t l;
        l = mk(PIN_H, PIN_H, LEN_S, PIN_H, DS_CONST, DATA_DONT_CARE, 1'b1);
        case (rt)
            RT_DA, RT_SA, RT_DEL, RT_ADD: begin
                case (step)
                    4'h0: l = mk(PIN_H, PIN_L, LEN_S, PIN_H,
                        (rt == RT_ADD) ? DS_W0 : DS_CONST,
                        DATA_DONT_CARE, 1'b0);
                    4'h1: l = mk(PIN_H, PIN_L, LEN_S, PIN_H, DS_A0,
                        DATA_DONT_CARE, 1'b0);
                    4'h2: l = mk(PIN_H, PIN_L, LEN_S, PIN_H, DS_A1,
                        DATA_DONT_CARE, 1'b0);
                    4'h3: l = mk(PIN_H, PIN_L, (rt == RT_DA) ? LEN_L : LEN_S,
                        (rt == RT_ADD) ? PIN_H : PIN_L, DS_A2,
                        DATA_DONT_CARE, 1'b0);
                    default: begin
                        if (rt == RT_DA)
                            l = mk(PIN_H, PIN_H, LEN_L, PIN_H, DS_CONST,
                                DATA_DONT_CARE, 1'b1);
                        else if (rt == RT_SA)
                            l = mk(PIN_L, PIN_L, LEN_L, PIN_H,
                                hit ? DS_OPU : DS_OPL, DATA_DONT_CARE, 1'b1);
                        else
                            l = mk(PIN_L, PIN_L, LEN_L, PIN_H, DS_CONST,
                                (rt == RT_DEL) ? CMD_EMPTY_HM : CMD_NEXT_FREE,
                                1'b1);
                    end
                endcase
            end
            RT_PURGE: begin
                case (step)
                    4'h0: l = mk(PIN_L, PIN_L, LEN_S, PIN_H, DS_CONST,
                        CMD_SEL_BG, 1'b0);
                    4'h1: l = mk(PIN_H, PIN_L, LEN_L, PIN_H, DS_TS,
                        DATA_DONT_CARE, 1'b0);
                    4'h2: l = mk(PIN_L, PIN_L, LEN_L, PIN_H, DS_CONST,
                        CMD_EMPTY_ALL, 1'b0);
                    default: l = mk(PIN_L, PIN_L, LEN_S, PIN_H, DS_CONST,
                        CMD_SEL_FG, 1'b1);
                endcase
            end
            RT_SETADD: begin
                case (step)
                    4'h0: l = mk(PIN_L, PIN_L, LEN_S, PIN_H, DS_CONST,
                        CMD_SEL_BG, 1'b0);
                    4'h1: l = mk(PIN_L, PIN_L, LEN_S, PIN_H, DS_CONST,
                        CMD_TGT_ADDR, 1'b0);
                    4'h2: l = mk(PIN_L, PIN_L, LEN_S, PIN_H, DS_W0,
                        DATA_DONT_CARE, 1'b0);
                    default: l = mk(PIN_L, PIN_L, LEN_S, PIN_H, DS_CONST,
                        CMD_SEL_FG, 1'b1);
                endcase
            end
            default: begin
                case (step)
                    4'h0: l = mk(PIN_L, PIN_L, LEN_S, PIN_H, DS_CONST,
                        CMD_SEL_BG, 1'b0);
                    4'h1, 4'h9: l = mk(PIN_L, PIN_L, LEN_S, PIN_H, DS_CONST,
                        CMD_TGT_DEV, 1'b0);
                    4'h2: l = mk(PIN_L, PIN_L, LEN_S, PIN_H, DS_W0,
                        DATA_DONT_CARE, 1'b0);
                    4'h3, 4'h4, 4'h5, 4'h6: l = mk(PIN_H, PIN_H, LEN_L, PIN_H,
                        DS_CONST, DATA_DONT_CARE, 1'b0);
                    4'h7, 4'h8: l = mk(PIN_L, PIN_H, LEN_M, PIN_H, DS_CONST,
                        DATA_DONT_CARE, 1'b0);
                    4'ha: l = mk(PIN_L, PIN_L, LEN_S, PIN_H, DS_CONST,
                        DATA_ALL_ONES, 1'b0);
                    default: l = mk(PIN_L, PIN_L, LEN_S, PIN_H, DS_CONST,
                        CMD_SEL_FG, 1'b1);
                endcase
            end
        endcase
        script_line = l;
    endfunction : script_line
endpackage : csq_pkg

// ---- hw/csq_strobe.sv ----
// Enable strobe timer: holds the enable low for a short, medium or long cycle
`timescale 1ns/1ps
module csq_strobe (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Control
    input wire logic start_i,
    input wire csq_pkg::csq_len_t len_i,
    // Strobe
    output logic enable_b_o,
    output logic end_o
);
    import csq_pkg::*;

    logic [7:0] cnt_r;

    // Last low cycle of the strobe; the caller samples the CAM here
    assign end_o = !enable_b_o && (cnt_r == 8'h00);

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            enable_b_o <= 1'b1;
            cnt_r <= 8'h00;
        end else if (start_i) begin
            enable_b_o <= 1'b0;
            cnt_r <= 8'(len_cycles(len_i) - 8'h01);
        end else if (end_o) begin
            enable_b_o <= 1'b1;
        end else if (!enable_b_o) begin
            cnt_r <= 8'(cnt_r - 8'h01);
        end
    end
endmodule : csq_strobe

// ---- hw/csq_sequencer.sv ----
// CAM routine sequencer: runs fixed cycle scripts on cascaded CAM chips
`timescale 1ns/1ps
module csq_sequencer (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Frame parser requests
    input wire logic da_go_i,
    input wire logic [47:0] da_addr_i,
    input wire logic sa_go_i,
    input wire logic [47:0] sa_addr_i,
    // Software triggers
    input wire logic purge_go_i,
    input wire logic add_go_i,
    input wire logic del_go_i,
    input wire logic setadd_go_i,
    input wire logic read_go_i,
    // Software data words
    input wire logic [15:0] cmd_word0_i,
    input wire logic [15:0] cmd_word1_i,
    input wire logic [15:0] cmd_word2_i,
    input wire logic [15:0] cmd_word3_i,
    input wire logic [15:0] purge_ts_i,
    input wire logic [15:0] sa_opcode_upper_i,
    input wire logic [15:0] sa_opcode_lower_i,
    // CAM bus
    input wire logic [15:0] cam_dq_i,
    output logic [15:0] cam_dq_o,
    output logic cam_dq_oe_b_o,
    output logic cam_command_select_b_o,
    output logic cam_write_b_o,
    output logic cam_enable_b_o,
    output logic cam_compare_strobe_b_o,
    input wire logic cam_full_input_b_i,
    input wire logic cam_match_input_b_i,
    // Results
    output logic busy_o,
    output logic da_done_o,
    output logic da_match_o,
    output logic [15:0] da_assoc_o,
    output logic sa_done_o,
    output logic sa_learned_o,
    output logic sa_full_o,
    output logic sw_done_o,
    output logic rd_valid_o,
    output logic [2:0] rd_idx_o,
    output logic [15:0] rd_word_o
);
    import csq_pkg::*;

    csq_state_t state_r, state_nxt;
    csq_rt_t rt_r;
    logic [3:0] step_r;
    logic hit_r;
    logic [6:0] pend_r;
    logic [47:0] da_addr_r, sa_addr_r, run_addr_r;
    logic [7:0] low_cnt_r;

    csq_line_t line;
    csq_rt_t pick;
    logic [6:0] go_vec, clr_vec;
    logic [47:0] start_addr;
    logic [15:0] line_data;
    logic any_pend, cyc_end, skip, fin, in_cyc, rd_step;

    function automatic csq_rt_t first_pending(input logic [6:0] p);
        first_pending = RT_DA;
        for (int i = 6; i >= 0; i--) begin
            if (p[i])
                first_pending = csq_rt_t'(i);
        end
    endfunction : first_pending

    // Frame searches outrank software routines
    assign go_vec = {read_go_i, setadd_go_i, del_go_i, add_go_i, purge_go_i,
        sa_go_i, da_go_i};
    assign any_pend = |pend_r;
    assign pick = first_pending(pend_r);
    assign clr_vec = (state_r == ST_IDLE && any_pend) ?
        7'(7'h01 << pick) : 7'h00;
    assign start_addr = (pick == RT_DA) ? da_addr_r :
        (pick == RT_SA) ? sa_addr_r :
        (pick == RT_ADD) ? {cmd_word3_i, cmd_word2_i, cmd_word1_i} :
        (pick == RT_DEL) ? {cmd_word2_i, cmd_word1_i, cmd_word0_i} : 48'h0;

    assign line = script_line(rt_r, step_r, hit_r);
    assign line_data = (line.dsel == DS_A0) ? run_addr_r[47:32] :
        (line.dsel == DS_A1) ? run_addr_r[31:16] :
        (line.dsel == DS_A2) ? run_addr_r[15:0] :
        (line.dsel == DS_W0) ? cmd_word0_i :
        (line.dsel == DS_TS) ? purge_ts_i :
        (line.dsel == DS_OPU) ? sa_opcode_upper_i :
        (line.dsel == DS_OPL) ? sa_opcode_lower_i :
        line.cval;

    assign in_cyc = (state_r == ST_CYC) && cyc_end;
    // A miss with every chip full cannot learn, so the script stops early
    assign skip = (rt_r == RT_SA) && (step_r == STEP_CMP) &&
        cam_match_input_b_i && !cam_full_input_b_i;
    assign fin = in_cyc && (line.last || skip);
    assign rd_step = (rt_r == RT_READ) && (step_r >= RD_FIRST_STEP) &&
        (step_r <= RD_LAST_STEP);

    csq_strobe u_strobe (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .start_i(state_r == ST_ARM),
        .len_i(line.len),
        .enable_b_o(cam_enable_b_o),
        .end_o(cyc_end)
    );

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: if (any_pend) state_nxt = ST_SETUP;
            ST_SETUP: state_nxt = ST_ARM;
            ST_ARM: state_nxt = ST_CYC;
            default: if (fin) state_nxt = ST_IDLE;
                else if (cyc_end) state_nxt = ST_SETUP;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pend_r <= 7'h00;
            da_addr_r <= 48'h0;
            sa_addr_r <= 48'h0;
        end else begin
            // A request in the cycle its bit is cleared stays pending
            pend_r <= (pend_r & ~clr_vec) | go_vec;
            if (da_go_i) da_addr_r <= da_addr_i;
            if (sa_go_i) sa_addr_r <= sa_addr_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= ST_IDLE;
            rt_r <= RT_DA;
            step_r <= 4'h0;
            hit_r <= 1'b0;
            run_addr_r <= 48'h0;
        end else begin
            state_r <= state_nxt;
            if (state_r == ST_IDLE && any_pend) begin
                rt_r <= pick;
                step_r <= 4'h0;
                hit_r <= 1'b0;
                run_addr_r <= start_addr;
            end else if (in_cyc) begin
                step_r <= 4'(step_r + 4'h1);
                if (!line.ec_b) hit_r <= !cam_match_input_b_i;
            end
        end
    end

    // Pins settle one cycle before the enable falls
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cam_command_select_b_o <= PIN_H;
            cam_write_b_o <= PIN_H;
            cam_compare_strobe_b_o <= PIN_H;
            cam_dq_oe_b_o <= PIN_H;
            cam_dq_o <= 16'h0000;
        end else if (state_r == ST_SETUP) begin
            cam_command_select_b_o <= line.cm_b;
            cam_write_b_o <= line.w_b;
            cam_compare_strobe_b_o <= line.ec_b;
            cam_dq_oe_b_o <= line.w_b;
            cam_dq_o <= line.w_b ? 16'h0000 : line_data;
        end else if (fin) begin
            cam_command_select_b_o <= PIN_H;
            cam_write_b_o <= PIN_H;
            cam_compare_strobe_b_o <= PIN_H;
            cam_dq_oe_b_o <= PIN_H;
            cam_dq_o <= 16'h0000;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_o <= 1'b0;
            da_done_o <= 1'b0;
            da_match_o <= 1'b0;
            da_assoc_o <= 16'h0000;
            sa_done_o <= 1'b0;
            sa_learned_o <= 1'b0;
            sa_full_o <= 1'b0;
            sw_done_o <= 1'b0;
        end else begin
            busy_o <= (state_nxt != ST_IDLE);
            da_done_o <= fin && (rt_r == RT_DA);
            sa_done_o <= fin && (rt_r == RT_SA);
            sw_done_o <= fin && (rt_r != RT_DA) && (rt_r != RT_SA);
            if (fin && rt_r == RT_DA) begin
                da_match_o <= (cam_dq_i != DATA_ALL_ONES);
                da_assoc_o <= cam_dq_i;
            end
            if (fin && rt_r == RT_SA) begin
                sa_learned_o <= !skip && !hit_r;
                sa_full_o <= skip;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_valid_o <= 1'b0;
            rd_idx_o <= 3'h0;
            rd_word_o <= 16'h0000;
        end else begin
            rd_valid_o <= in_cyc && rd_step;
            if (in_cyc && rd_step) begin
                rd_idx_o <= 3'(step_r - RD_FIRST_STEP);
                rd_word_o <= cam_dq_i;
            end
        end
    end

    // Helper for the cycle length check
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) low_cnt_r <= 8'h00;
        else if (cam_enable_b_o) low_cnt_r <= 8'h00;
        else low_cnt_r <= 8'(low_cnt_r + 8'h01);
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_sa_miss;
        in_cyc && rt_r == RT_SA && step_r == STEP_CMP &&
            cam_match_input_b_i && cam_full_input_b_i;
    endsequence
    sequence s_learn;
        !cam_enable_b_o && !cam_command_select_b_o && !cam_write_b_o &&
            cam_dq_o == sa_opcode_lower_i;
    endsequence
    sequence s_da_cmp;
        !cam_enable_b_o && rt_r == RT_DA && step_r == STEP_CMP;
    endsequence

    AST_CYCLE_LEN: assert property (
        $rose(cam_enable_b_o) |-> low_cnt_r == len_cycles($past(line.len)))
        else $error("enable low time differs from cycle length");
    AST_STROBES: assert property (
        !cam_enable_b_o |-> cam_command_select_b_o == line.cm_b &&
            cam_write_b_o == line.w_b)
        else $error("command or write strobe wrong during cycle");
    AST_DRIVE: assert property (
        !cam_enable_b_o |-> cam_dq_oe_b_o == cam_write_b_o &&
            $stable(cam_dq_o))
        else $error("data bus drive does not follow write strobe");
    AST_DA_CMP: assert property (
        s_da_cmp |-> !cam_compare_strobe_b_o && line.len == LEN_L &&
            cam_dq_o == run_addr_r[15:0])
        else $error("destination compare cycle wrong");
    AST_DA_RESULT: assert property (
        da_done_o |-> da_assoc_o == $past(cam_dq_i) &&
            da_match_o == ($past(cam_dq_i) != DATA_ALL_ONES))
        else $error("destination match flag wrong");
    AST_SA_LEARN: assert property (
        s_sa_miss |-> ##[1:8] s_learn)
        else $error("source miss did not learn");
    AST_SA_HIT: assert property (
        !cam_enable_b_o && rt_r == RT_SA && step_r == 4'h4 && hit_r
            |-> cam_dq_o == sa_opcode_upper_i)
        else $error("source hit opcode wrong");
    AST_FULL_SKIP: assert property (
        in_cyc && skip |=> sa_done_o && sa_full_o && !sa_learned_o)
        else $error("full list miss not reported");
    AST_READ_WORD: assert property (
        rd_valid_o |-> rd_word_o == $past(cam_dq_i) && $past(cam_write_b_o))
        else $error("read word not captured from read cycle");
    AST_ALL_DEV: assert property (
        !cam_enable_b_o && rt_r == RT_READ && step_r == RD_ALLDEV_STEP
            |-> cam_dq_o == DATA_ALL_ONES && !cam_command_select_b_o)
        else $error("all devices not reselected");
endmodule : csq_sequencer

// ---- hw/csq_end.sv ----
// No logic of its own: the sequencer and its strobe timer live beside it

// ---- tb/csq_cam_model.sv ----
// CAM stack model: returns read words and the cascaded full and match flags
`timescale 1ns/1ps
module csq_cam_model (
    // Clock
    input wire logic mclk_i,
    // Strobes from the sequencer
    input wire logic enable_b_i,
    input wire logic write_b_i,
    // Test controls
    input wire logic hit_i,
    input wire logic full_i,
    input wire logic [15:0] rdat_i,
    // Answers
    output logic [15:0] dq_o,
    output logic match_b_o,
    output logic full_b_o
);
    logic [15:0] last_r = 16'h0;
    logic [2:0] nrd_r = 3'h0;
    logic en_d_r = 1'b1;
    // Reads since the last write differ, so a wrong read order shows up
    assign dq_o = (!enable_b_i && write_b_i) ? (rdat_i ^ {13'h0, nrd_r})
        : ~last_r;
    // One model stands for the whole cascade on a shared bus
    assign match_b_o = ~hit_i;
    assign full_b_o = ~full_i;
    always @(posedge mclk_i) begin
        last_r <= dq_o;
        en_d_r <= enable_b_i;
        if (!enable_b_i && !write_b_i)
            nrd_r <= 3'h0;
        else if (enable_b_i && !en_d_r && write_b_i)
            nrd_r <= nrd_r + 3'h1;
    end
endmodule : csq_cam_model

// ---- tb/csq_sequencer_test.sv ----
// Testbench: runs every CAM routine and checks bus cycles and results
`timescale 1ns/1ps
module csq_sequencer_test;
    import csq_pkg::*;
    logic mclk_i = 1'b0, rst_b_i = 1'b0, hit = 1'b0, full = 1'b0;
    logic [6:0] go = 7'h0;
    logic [47:0] da_a = 48'h0, sa_a = 48'h0;
    logic [15:0] w [4] = '{default: 16'h0};
    logic [15:0] ts = 16'h0, rdat = 16'h0;
    logic [15:0] opu = 16'h0368, opl = 16'h0334;
    logic [15:0] dq_i, dq_o, da_assoc, rd_word;
    logic oe_b, cm_b, w_b, en_b, ec_b, match_b, full_b, busy;
    logic da_done, da_match, sa_done, sa_learned, sa_full, sw_done, rd_valid;
    logic [2:0] rd_idx;
    logic [23:0] log [$];
    logic [23:0] cur;
    int n_fail = 0, comparisons = 0, ecnt = 0, ridx = 0, seed = 80489;
    csq_rt_t rt;

    csq_sequencer dut_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .da_go_i(go[0]), .da_addr_i(da_a), .sa_go_i(go[1]), .sa_addr_i(sa_a),
        .purge_go_i(go[2]), .add_go_i(go[3]), .del_go_i(go[4]),
        .setadd_go_i(go[5]), .read_go_i(go[6]), .cmd_word0_i(w[0]),
        .cmd_word1_i(w[1]), .cmd_word2_i(w[2]), .cmd_word3_i(w[3]),
        .purge_ts_i(ts), .sa_opcode_upper_i(opu), .sa_opcode_lower_i(opl),
        .cam_dq_i(dq_i), .cam_dq_o(dq_o), .cam_dq_oe_b_o(oe_b),
        .cam_command_select_b_o(cm_b), .cam_write_b_o(w_b),
        .cam_enable_b_o(en_b), .cam_compare_strobe_b_o(ec_b),
        .cam_full_input_b_i(full_b), .cam_match_input_b_i(match_b),
        .busy_o(busy), .da_done_o(da_done), .da_match_o(da_match),
        .da_assoc_o(da_assoc), .sa_done_o(sa_done), .sa_learned_o(sa_learned),
        .sa_full_o(sa_full), .sw_done_o(sw_done), .rd_valid_o(rd_valid),
        .rd_idx_o(rd_idx), .rd_word_o(rd_word));
    csq_cam_model cam_u (.mclk_i(mclk_i), .enable_b_i(en_b),
        .write_b_i(w_b), .hit_i(hit), .full_i(full), .rdat_i(rdat),
        .dq_o(dq_i), .match_b_o(match_b), .full_b_o(full_b));

    always #5 mclk_i = ~mclk_i;

    task chk(input logic [23:0] got, input logic [23:0] want);
        comparisons++;
        if (got !== want) begin
            n_fail++;
            $display("Error at %0t: got %h want %h", $time, got, want);
        end
    endtask : chk

    task stop_test;
        $display("Comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    // Record each enable-low cycle as {care, cm, w, ec, length, data}
    always @(posedge mclk_i) begin
        if (en_b === 1'b0) begin
            ecnt++;
            cur = {1'b0, cm_b, w_b, ec_b, 4'(ecnt), oe_b ? dq_i : dq_o};
            chk(24'(oe_b), 24'(w_b));
        end else if (ecnt != 0) begin
            log.push_back(cur);
            ecnt = 0;
        end
        if (rd_valid === 1'b1) begin
            chk({rd_idx, rd_word}, {3'(ridx), rdat ^ 16'(ridx)});
            ridx++;
        end
    end

    function automatic logic [23:0] ln(logic c, logic wr, logic e, int n,
            logic [15:0] d, logic k);
        return {k, c, wr, e, 4'(n), d};
    endfunction : ln

    function automatic logic [23:0] expect_line(csq_rt_t r, int s);
        logic [47:0] a;
        a = (r == RT_DA) ? da_a : (r == RT_SA) ? sa_a :
            (r == RT_ADD) ? {w[3], w[2], w[1]} : {w[2], w[1], w[0]};
        if (r == RT_PURGE)
            return (s == 1) ? ln(1, 0, 1, LONG_CYC, ts, 1) :
                (s == 2) ? ln(0, 0, 1, LONG_CYC, 16'h043d, 1) :
                ln(0, 0, 1, SHORT_CYC, s == 0 ? 16'h0619 : 16'h0618, 1);
        if (r == RT_SETADD)
            return ln(0, 0, 1, SHORT_CYC, (s == 0) ? 16'h0619 :
                (s == 1) ? 16'h0220 : (s == 2) ? w[0] : 16'h0618, 1);
        if (r == RT_READ)
            return (s > 2 && s < 7) ?
                ln(1, 1, 1, LONG_CYC, rdat ^ 16'(s - 3), 1) :
                (s == 7 || s == 8) ?
                ln(0, 1, 1, MED_CYC, rdat ^ 16'(s - 3), 1) :
                ln(0, 0, 1, SHORT_CYC, (s == 0) ? 16'h0619 :
                (s == 2) ? w[0] : (s == 10) ? 16'hffff :
                (s == 11) ? 16'h0618 : 16'h0228, 1);
        if (s == 0)
            return ln(1, 0, 1, SHORT_CYC, w[0], r == RT_ADD);
        if (s < 4)
            return ln(1, 0, !(s == 3 && r != RT_ADD),
                (s == 3 && r == RT_DA) ? LONG_CYC : SHORT_CYC,
                a[63 - 16 * s -: 16], 1);
        if (r == RT_DA)
            return ln(1, 1, 1, LONG_CYC, rdat, 1);
        return ln(0, 0, 1, LONG_CYC, (r == RT_SA) ? (hit ? opu : opl) :
            (r == RT_ADD) ? 16'h0334 : 16'h042d, 1);
    endfunction : expect_line

    task automatic run(csq_rt_t r);
        int n, t;
        logic [23:0] e, m;
        n = (r == RT_READ) ? 12 : (r == RT_PURGE || r == RT_SETADD ||
            (r == RT_SA && !hit && full)) ? 4 : 5;
        log.delete();
        ridx = 0;
        t = 0;
        go[r] = 1'b1;
        @(posedge mclk_i);
        #1 go = 7'h0;
        do begin
            @(posedge mclk_i);
            #1 t++;
        end while (!(r == RT_DA ? da_done : r == RT_SA ? sa_done : sw_done)
            && t < 500);
        if (t >= 500) begin
            n_fail++;
            stop_test();
        end
        if (r == RT_DA)
            chk({da_match, da_assoc}, {rdat != 16'hffff, rdat});
        if (r == RT_SA)
            chk({sa_learned, sa_full}, {!hit && !full, !hit && full});
        // The last cycle is logged one edge after the done pulse
        @(posedge mclk_i);
        #1 chk(24'(log.size()), 24'(n));
        for (int s = 0; s < n && s < log.size(); s++) begin
            e = expect_line(r, s);
            m = e[23] ? 24'h7fffff : 24'h7f0000;
            chk(log[s] & m, e & m);
        end
        chk(24'(busy), 24'h0);
        $display("Test of routine %0d ended", r);
    endtask : run

    initial begin
        repeat (3) @(posedge mclk_i);
        #1 rst_b_i = 1'b1;
        for (int i = 0; i < 30; i++) begin
            rt = csq_rt_t'((i < 7) ? i : (i == 8) ? 0 : (i == 9) ? 1 :
                $unsigned($random(seed)) % 7);
            {da_a, sa_a} = {$random(seed), $random(seed), $random(seed)};
            foreach (w[k]) w[k] = 16'($random(seed));
            ts = 16'($random(seed));
            // All ones read back means no match; a full miss skips learning
            rdat = (i == 8) ? 16'hffff : 16'($random(seed));
            {hit, full} = (i == 9) ? 2'b01 : 2'($random(seed));
            if (rt == RT_ADD)
                w[0] = {w[0][15], 1'b0, w[0][13:8], 8'h00};
            run(rt);
        end
        // Reset in mid-routine must drop every strobe and the busy flag
        ridx = 0;
        go[RT_READ] = 1'b1;
        @(posedge mclk_i);
        #1 go = 7'h0;
        repeat (20) @(posedge mclk_i);
        #1 chk(24'(busy), 24'h1);
        rst_b_i = 1'b0;
        @(posedge mclk_i);
        #1 chk({busy, en_b, cm_b, w_b, oe_b, ec_b}, 24'h1f);
        rst_b_i = 1'b1;
        $display("Test of reset in mid-routine ended");
        run(RT_DA);
        stop_test();
    end

    // Thirty-one routines and a reset test of at most a few hundred cycles each
    initial begin
        #200000;
        n_fail++;
        stop_test();
    end
endmodule : csq_sequencer_test
